/* core/cct_pkg.sv */
// Package for the multimode counter/timer channel: register map, control field layout,
// mode and source codes, and timing counts.
// Assumes a 100 MHz core clock; every cycle count below derives from that period.
package cct_pkg;

  // Core clock period in picoseconds (100 MHz)
  localparam int unsigned CLK_PS = 10000;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_BOARD = 8'h00;
  localparam logic [7:0] IDX_STAT = 8'h02;
  localparam logic [7:0] IDX_TRIG = 8'h04;
  localparam logic [7:0] IDX_CTRL = 8'h06;
  localparam logic [7:0] IDX_CONST_A = 8'h07;
  localparam logic [7:0] IDX_CONST_B = 8'h08;
  localparam logic [7:0] IDX_READBACK = 8'h09;
  localparam logic [7:0] ADDR_BOARD = IDX_BOARD * 8'h04;
  localparam logic [7:0] ADDR_STAT = IDX_STAT * 8'h04;
  localparam logic [7:0] ADDR_TRIG = IDX_TRIG * 8'h04;
  localparam logic [7:0] ADDR_CTRL = IDX_CTRL * 8'h04;
  localparam logic [7:0] ADDR_CONST_A = IDX_CONST_A * 8'h04;
  localparam logic [7:0] ADDR_CONST_B = IDX_CONST_B * 8'h04;
  localparam logic [7:0] ADDR_READBACK = IDX_READBACK * 8'h04;

  // Control register field positions
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned POL_BIT = 3;
  localparam int unsigned GATE_LSB = 4;
  localparam int unsigned AUX_LSB = 6;
  localparam int unsigned TRIG_LSB = 8;
  localparam int unsigned SRC_LSB = 10;
  localparam int unsigned DEB_BIT = 13;
  localparam int unsigned IE_BIT = 15;
  localparam int unsigned CARRIER_BIT = 0;
  localparam int unsigned STAT_BIT = 0;

  // Reset values and write mask (bit 14 never stores)
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
  localparam logic [15:0] BOARD_RESET = 16'h0000;
  localparam logic [15:0] CONST_RESET = 16'h0000;

  // Mode, source and polarity codes
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_WD = 3'h3;
  localparam logic [2:0] MODE_EVT = 3'h4;
  localparam logic [2:0] SRC_EVT = 3'h0;
  localparam logic [2:0] SRC_MAX_INT = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_HIGH = 2'h2;
  localparam logic [1:0] TRIG_UPDN = 2'h3;

  // Input filter and event output pulse
  localparam int unsigned DEB_NS = 2500;
  localparam logic [8:0] DEB_CYC = 9'((DEB_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam int unsigned PULSE_NS = 1750;
  localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // Internal clock dividers, indexed by clock source code 0..4
  localparam logic [7:0] DIV_8M [0:4] = '{8'(2000000 / CLK_PS), 8'(1000000 / CLK_PS),
    8'(500000 / CLK_PS), 8'(250000 / CLK_PS), 8'(125000 / CLK_PS)};
  localparam logic [7:0] DIV_32M [0:4] = '{8'(500000 / CLK_PS), 8'(250000 / CLK_PS),
    8'(125000 / CLK_PS), 8'(62500 / CLK_PS), 8'(31250 / CLK_PS)};

  // Channel run state
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_DONE = 3'h4
  } cct_state_type;

endpackage

/* core/cct_cond_if.sv */
// Interface joining the channel core to its input conditioner.
// Carries raw pins in, the debounce enable, and cleaned levels out.
`timescale 1ns/1ps
interface cct_cond_if;
  logic [2:0] raw;
  logic deb_en;
  logic [2:0] clean;
  modport conditioner (input raw, input deb_en, output clean);
  modport user (output raw, output deb_en, input clean);
endinterface

/* core/cct_input_cond.sv */
// Input conditioner: two-flop synchroniser and optional pulse filter per input.
// Assumes the raw inputs may be asynchronous; bit 0 gate, bit 1 aux, bit 2 trigger.
`timescale 1ns/1ps
module cct_input_cond
  import cct_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  cct_cond_if.conditioner cond
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] clean;
    logic [2:0][8:0] cnt;
  } cct_cond_type;

  cct_cond_type r_ff;
  cct_cond_type nxt_r;
  logic [2:0] nxt_clean;
  logic [2:0][8:0] nxt_cnt;

  // Per input: follow at once when unfiltered, else only after a stable run past the limit
  for (genvar i = 0; i < 3; i++) begin : g_in
    always_comb begin
      nxt_clean[i] = r_ff.clean[i];
      nxt_cnt[i] = 9'h000;
      if (r_ff.s2[i] != r_ff.clean[i]) begin
        if (!cond.deb_en) begin
          nxt_clean[i] = r_ff.s2[i];
        end else if (r_ff.cnt[i] >= DEB_CYC) begin
          nxt_clean[i] = r_ff.s2[i];
        end else begin
          nxt_cnt[i] = 9'(r_ff.cnt[i] + 9'h001);
        end
      end
    end
  end

  // Next state; first stage feeds only the second
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = cond.raw;
    nxt_r.s2 = r_ff.s1;
    nxt_r.clean = nxt_clean;
    nxt_r.cnt = nxt_cnt;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign cond.clean = r_ff.clean;

  // A pulse no longer than the limit never reaches the cleaned output
  chk_deb_reject: assert property (@(posedge i_clock) disable iff (i_rst)
    (cond.deb_en && r_ff.s2[0] != r_ff.clean[0] && r_ff.cnt[0] < DEB_CYC) |=> $stable(r_ff.clean[0]))
    else $error("gate input changed before the filter time");

endmodule

/* core/cct_channel.sv */
// Counter/timer channel with PWM, watchdog and event counting modes behind an APB slave.
// Assumes APB master in the i_clock domain and raw input pins that may be asynchronous.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - Mode 010 is PWM, 011 is watchdog
// - Event counting needs mode 100, source 000
// - Bit 3 sets output level; idle high
// - Sources 0-4 internal rates, 101 external
// - Aux clock needs polarity 01/10, source 101
// - Gate field sets counting level or disables
// - Trigger pin edge or register write starts
// - Filter drops input pulses of 2.5 us
// - Watchdog counts down, active until zero
// - Timed-out watchdog waits for reload and trigger
// - Gate level or constant write reloads watchdog
// - Limit N times out after N ticks
// - Readback shows live count, no side effect
// - Watchdog interrupt clears after reload and write
// - Event match pulses output, clears, keeps counting
// - Trigger field 11 selects up/down, floor zero
// - Watchdog trigger field 11 continues or pauses
// - Event interrupt clears by write or bit 15
// - PWM alternates delay and active countdowns
// - PWM interrupts on every output edge
module cct_channel
  import cct_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_gate_reload_input,
  input wire logic i_aux_clock_event_input,
  input wire logic i_trigger_input,
  output logic o_out,
  output logic o_out_oe_n,
  output logic o_irq
);

  typedef struct packed {
    cct_state_type st;
    logic [15:0] ctrl;
    logic [15:0] board;
    logic [15:0] const_a;
    logic [15:0] const_b;
    logic [15:0] cnt;
    logic [7:0] pre;
    logic [7:0] pulse;
    logic phase;
    logic pend;
    logic reinit;
    logic aux_q;
    logic trig_q;
    logic [31:0] rdata;
  } cct_regs_type;

  cct_regs_type r_ff;
  cct_regs_type nxt_r;

  cct_cond_if cond ();

  cct_input_cond u_cond (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .cond(cond)
  );

  // Raw pins into the conditioner; filter enable straight from control
  assign cond.raw = {i_trigger_input, i_aux_clock_event_input, i_gate_reload_input};
  assign cond.deb_en = r_ff.ctrl[DEB_BIT];

  logic gate_in, aux_in, trig_in;
  logic [2:0] mode, src;
  logic [1:0] gpol, apol, tpol;
  logic mode_pwm, mode_wd, mode_ev, running_mode;
  assign gate_in = cond.clean[0];
  assign aux_in = cond.clean[1];
  assign trig_in = cond.clean[2];
  assign mode = r_ff.ctrl[MODE_LSB +: 3];
  assign src = r_ff.ctrl[SRC_LSB +: 3];
  assign gpol = r_ff.ctrl[GATE_LSB +: 2];
  assign apol = r_ff.ctrl[AUX_LSB +: 2];
  assign tpol = r_ff.ctrl[TRIG_LSB +: 2];
  assign mode_pwm = (mode == MODE_PWM);
  assign mode_wd = (mode == MODE_WD);
  assign mode_ev = (mode == MODE_EVT) && (src == SRC_EVT);
  assign running_mode = mode_pwm || mode_wd || mode_ev;

  // Input decoding: active levels and edges of the cleaned inputs
  logic aux_act, aux_edge, trig_lvl, trig_edge, gate_ok, reload_act, cont_ok, count_down;
  assign aux_act = (apol == POL_LOW) ? !aux_in : aux_in;
  assign aux_edge = aux_act && !r_ff.aux_q && (apol == POL_LOW || apol == POL_HIGH);
  assign trig_lvl = (tpol == POL_LOW) ? !trig_in : trig_in;
  assign trig_edge = trig_lvl && !r_ff.trig_q && (tpol == POL_LOW || tpol == POL_HIGH);
  assign gate_ok = (gpol == POL_LOW) ? !gate_in : ((gpol == POL_HIGH) ? gate_in : 1'b1);
  assign reload_act = (gpol == POL_LOW && !gate_in) || (gpol == POL_HIGH && gate_in);
  assign cont_ok = (tpol != TRIG_UPDN) || trig_in;
  assign count_down = (tpol == TRIG_UPDN) && trig_in;

  // Counting clock: divided core clock or aux edges; the divided rate truncates to whole cycles
  logic int_ok, ext_sel, int_tick, tick;
  logic [7:0] div;
  assign int_ok = (src <= SRC_MAX_INT);
  assign div = !int_ok ? 8'h01 : (r_ff.board[CARRIER_BIT] ? DIV_32M[src] : DIV_8M[src]);
  assign int_tick = int_ok && (r_ff.pre >= 8'(div - 8'h01));
  assign ext_sel = (src == SRC_EXT) && (apol == POL_LOW || apol == POL_HIGH);
  assign tick = ext_sel ? aux_edge : int_tick;

  // APB decode; zero wait states, so the answer sits in the access cycle
  logic setup, access, wr, hit, sw_trig, wr_ctrl, wr_a, wr_stat;
  logic [31:0] rd_mux;
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite;
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (i_paddr)
      ADDR_BOARD: rd_mux = {16'h0000, r_ff.board};
      ADDR_STAT: rd_mux = {31'h0000_0000, r_ff.pend};
      ADDR_TRIG: rd_mux = 32'h0000_0000;
      ADDR_CTRL: rd_mux = {16'h0000, r_ff.ctrl};
      ADDR_CONST_A: rd_mux = {16'h0000, r_ff.const_a};
      ADDR_CONST_B: rd_mux = {16'h0000, r_ff.const_b};
      ADDR_READBACK: rd_mux = {16'h0000, r_ff.cnt};
      default: hit = 1'b0;
    endcase
  end
  assign sw_trig = wr && (i_paddr == ADDR_TRIG);
  assign wr_ctrl = wr && (i_paddr == ADDR_CTRL);
  assign wr_a = wr && (i_paddr == ADDR_CONST_A);
  assign wr_stat = wr && (i_paddr == ADDR_STAT);

  logic start;
  assign start = sw_trig || trig_edge;

  // Channel next state; hardware events are applied after status-write clears so a set wins over them, but a cleared bit 15 still clears
  logic irq_ev;
  logic [15:0] ev_val;
  always_comb begin
    nxt_r = r_ff;
    irq_ev = 1'b0;
    ev_val = 16'h0000;
    nxt_r.aux_q = aux_act;
    nxt_r.trig_q = trig_lvl;
    nxt_r.pre = int_tick ? 8'h00 : 8'(r_ff.pre + 8'h01);
    if (!int_ok) begin
      nxt_r.pre = 8'h00;
    end
    if (r_ff.pulse != 8'h00) begin
      nxt_r.pulse = 8'(r_ff.pulse - 8'h01);
    end
    unique case (r_ff.st)
      ST_IDLE: begin
        if (start && running_mode) begin
          nxt_r.st = ST_RUN;
          nxt_r.phase = 1'b0;
          if (mode_pwm) begin
            nxt_r.cnt = r_ff.const_a;
          end else if (mode_ev) begin
            nxt_r.cnt = 16'h0000;
          end
        end
      end
      ST_RUN: begin
        if (!running_mode) begin
          nxt_r.st = ST_IDLE;
        end else if (mode_pwm) begin
          if (tick && gate_ok) begin
            if (r_ff.cnt <= 16'h0001) begin
              nxt_r.phase = !r_ff.phase;
              nxt_r.cnt = r_ff.phase ? r_ff.const_a : r_ff.const_b;
              irq_ev = 1'b1;
            end else begin
              nxt_r.cnt = 16'(r_ff.cnt - 16'h0001);
            end
          end
        end else if (mode_wd) begin
          if (reload_act) begin
            nxt_r.cnt = r_ff.const_a;
            nxt_r.reinit = 1'b1;
          end else if (r_ff.cnt == 16'h0000) begin
            nxt_r.st = ST_DONE;
            nxt_r.reinit = 1'b0;
            irq_ev = 1'b1;
          end else if (tick && cont_ok) begin
            nxt_r.cnt = 16'(r_ff.cnt - 16'h0001);
            if (r_ff.cnt == 16'h0001) begin
              nxt_r.st = ST_DONE;
              nxt_r.reinit = 1'b0;
              irq_ev = 1'b1;
            end
          end
        end else begin
          if (aux_edge && gate_ok) begin
            if (count_down) begin
              ev_val = (r_ff.cnt == 16'h0000) ? 16'h0000 : 16'(r_ff.cnt - 16'h0001);
            end else begin
              ev_val = 16'(r_ff.cnt + 16'h0001);
            end
            if (ev_val == r_ff.const_a) begin
              nxt_r.cnt = 16'h0000;
              nxt_r.pulse = PULSE_CYC;
              irq_ev = 1'b1;
            end else begin
              nxt_r.cnt = ev_val;
            end
          end
        end
      end
      ST_DONE: begin
        if (!mode_wd) begin
          nxt_r.st = ST_IDLE;
        end else begin
          if (reload_act) begin
            nxt_r.cnt = r_ff.const_a;
            nxt_r.reinit = 1'b1;
          end
          if (start) begin
            nxt_r.st = ST_RUN;
          end
        end
      end
    endcase
    // Register writes
    if (wr_ctrl) begin
      nxt_r.ctrl = i_pwdata[15:0] & CTRL_WMASK;
    end
    if (wr && i_paddr == ADDR_BOARD) begin
      nxt_r.board = i_pwdata[15:0];
    end
    if (wr && i_paddr == ADDR_CONST_B) begin
      nxt_r.const_b = i_pwdata[15:0];
    end
    if (wr_a) begin
      nxt_r.const_a = i_pwdata[15:0];
      if (mode_wd) begin
        nxt_r.cnt = i_pwdata[15:0];
        nxt_r.reinit = 1'b1;
      end
    end
    // Watchdog clear only takes once the timer has been reloaded
    if (wr_stat && i_pwdata[STAT_BIT] && (!mode_wd || r_ff.reinit)) begin
      nxt_r.pend = 1'b0;
    end
    if (!nxt_r.ctrl[IE_BIT]) begin
      nxt_r.pend = 1'b0;
    end else if (irq_ev && r_ff.ctrl[IE_BIT]) begin
      nxt_r.pend = 1'b1;
    end
    if (setup) begin
      nxt_r.rdata = rd_mux;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_ff <= '{st: ST_IDLE, ctrl: CTRL_RESET, board: BOARD_RESET, const_a: CONST_RESET,
                const_b: CONST_RESET, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Output pin: released (pulled high) outside the three modes
  logic drive, active;
  assign drive = running_mode;
  assign active = (mode_pwm && r_ff.st == ST_RUN && r_ff.phase) || (mode_wd && r_ff.st == ST_RUN) ||
                  (mode_ev && r_ff.pulse != 8'h00);
  assign o_out = drive ? (active ? r_ff.ctrl[POL_BIT] : !r_ff.ctrl[POL_BIT]) : 1'b1;
  assign o_out_oe_n = !drive;
  assign o_irq = r_ff.pend;
  assign o_prdata = r_ff.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_idle_high: assert property (!drive |-> (o_out && o_out_oe_n))
    else $error("output not released high when idle");
  chk_wd_level: assert property ((mode_wd && r_ff.st == ST_RUN) |-> o_out == r_ff.ctrl[POL_BIT])
    else $error("watchdog output not active while counting");
  chk_wd_timeout: assert property ((mode_wd && r_ff.st == ST_RUN && r_ff.cnt == 16'h0001 && tick && cont_ok
    && !reload_act && !wr) |=> (r_ff.st == ST_DONE && r_ff.cnt == 16'h0000))
    else $error("watchdog did not time out at zero");
  chk_done_hold: assert property ((mode_wd && r_ff.st == ST_DONE && !reload_act && !wr_a && !wr_ctrl)
    |=> r_ff.cnt == $past(r_ff.cnt))
    else $error("timed-out watchdog count moved");
  chk_consta_load: assert property ((wr_a && mode_wd) |=> r_ff.cnt == $past(i_pwdata[15:0]))
    else $error("constant write did not load watchdog count");
  chk_wd_pause: assert property ((mode_wd && r_ff.st == ST_RUN && tpol == TRIG_UPDN && !trig_in && !reload_act
    && r_ff.cnt != 16'h0000 && !wr) |=> $stable(r_ff.cnt))
    else $error("watchdog counted while paused");
  chk_wd_irq: assert property ((mode_wd && r_ff.st == ST_RUN && r_ff.cnt == 16'h0000 && !reload_act
    && r_ff.ctrl[IE_BIT] && !wr) |=> (o_irq && r_ff.st == ST_DONE))
    else $error("watchdog timeout raised no interrupt");
  chk_ev_floor: assert property ((mode_ev && r_ff.st == ST_RUN && count_down && r_ff.cnt == 16'h0000
    && r_ff.const_a != 16'h0000 && !wr) |=> r_ff.cnt == 16'h0000)
    else $error("event count went below zero");
  chk_ev_pulse: assert property ($rose(mode_ev && r_ff.pulse != 8'h00) |-> (o_out == r_ff.ctrl[POL_BIT]) [*8])
    else $error("event output pulse too short");
  chk_ie_clear: assert property (!r_ff.ctrl[IE_BIT] |-> !o_irq)
    else $error("interrupt pending with service disabled");
  chk_pwm_toggle: assert property ((mode_pwm && r_ff.st == ST_RUN && tick && gate_ok && r_ff.cnt <= 16'h0001
    && !wr_ctrl) |=> (r_ff.phase != $past(r_ff.phase)))
    else $error("PWM phase did not toggle at zero");
  chk_rsvd_zero: assert property (wr_ctrl |=> !r_ff.ctrl[14])
    else $error("reserved control bit stored");

  cov_wd_timeout: cover property (mode_wd && r_ff.st == ST_RUN ##1 r_ff.st == ST_DONE);
  cov_ev_match: cover property ($rose(r_ff.pulse != 8'h00));
  cov_pwm_cycle: cover property (mode_pwm && !r_ff.phase ##[1:1000] r_ff.phase);
  cov_irq_clear: cover property (o_irq ##1 !o_irq);

endmodule

/* verification/cct_host_model.sv */
// Host carrier model: an APB master that issues one register transfer at a time.
// Assumes the bench calls xfer hierarchically and never overlaps two calls.
`timescale 1ns/1ps
module cct_host_model (
  input wire logic i_clock,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  logic last_err;

  // Bus idle from time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h00000000;
    last_err = 1'b0;
  end

  // Setup, then access held until pready is seen high; no cycle count is assumed
  task automatic xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata);
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr_en;
    o_paddr <= addr;
    o_pwdata <= wdata;
    @(posedge i_clock);
    o_penable <= 1'b1;
    @(posedge i_clock);
    while (i_pready !== 1'b1) @(posedge i_clock);
    rdata = i_prdata;
    last_err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released data is inverted so the slave cannot lean on stale values
    o_pwdata <= ~wdata;
  endtask
endmodule

/* verification/multimode_counter_timer_channel_test.sv */
// Self-checking bench for the counter/timer channel, one task per scenario.
// Assumes the host model drives APB and the bench drives the three input pins.
`timescale 1ns/1ps
module multimode_counter_timer_channel_test;
  import cct_pkg::*;
  logic i_clock, i_rst, psel, penable, pwrite, pready, pslverr, gate, aux, trig, out, oe_n, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, r1;
  int err_count, samples_checked, cyc, t0;

  cct_channel dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_gate_reload_input(gate), .i_aux_clock_event_input(aux),
    .i_trigger_input(trig), .o_out(out), .o_out_oe_n(oe_n), .o_irq(irq));
  cct_host_model host (.i_clock(i_clock), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

  // 100 MHz clock and a free cycle count for timing checks
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) cyc <= cyc + 1;

  // Bus helpers settle 1 ns past the edge so registered outputs have landed
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rv);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h00000000, rv);
    #1;
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wait_out(input logic lvl);
    int n;
    n = 0;
    while (out !== lvl && n < 3000) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    // A wait that runs out shows up as a mismatch here
    chk(out, lvl);
  endtask
  // One event: 20 cycles active, 20 idle, well above the minimum width
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge i_clock);
      aux <= 1'b1;
      cw(19);
      @(posedge i_clock);
      aux <= 1'b0;
      cw(20);
    end
  endtask
  task automatic set_trig(input logic v);
    @(posedge i_clock);
    trig <= v;
  endtask
  task automatic set_gate(input logic v);
    @(posedge i_clock);
    gate <= v;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic t_reset();
    chk(out, 1'b1);
    chk(oe_n, 1'b1);
    chk(irq, 1'b0);
    rd(ADDR_CTRL);
    chk(rv, 32'h00000000);
    wr(ADDR_CTRL, 32'h0000FFFF);
    rd(ADDR_CTRL);
    chk(rv, 32'h0000BFFF);
    chk(pready, 1'b1);
    rd(8'h3C);
    chk(host.last_err, 1'b1);
    chk(rv, 32'h00000000);
    wr(ADDR_CTRL, 32'h00000000);
  endtask

  // Watchdog on internal source src with tick period per, active high, interrupt enabled
  task automatic t_wd(input logic car, input logic [2:0] src, input int per);
    wr(ADDR_BOARD, {31'h0, car});
    wr(ADDR_CTRL, {16'h0000, 3'b100, src, 10'h00B});
    wr(ADDR_CONST_A, 32'h00000014);
    chk(oe_n, 1'b0);
    wr(ADDR_TRIG, 32'h00000001);
    t0 = cyc;
    chk(out, 1'b1);
    rd(ADDR_READBACK);
    r1 = rv;
    chk_rng(rv, 1, 20);
    rd(ADDR_READBACK);
    chk_rng(rv, 0, r1);
    wait_out(1'b0);
    chk_rng(32'(cyc - t0), 32'(20 * per - per - 4), 32'(20 * per + per + 4));
    chk(irq, 1'b1);
    wr(ADDR_TRIG, 32'h00000001);
    cw(4 * per);
    chk(out, 1'b0);
    rd(ADDR_READBACK);
    chk(rv, 32'h00000000);
    wr(ADDR_STAT, 32'h00000001);
    chk(irq, 1'b1);
    wr(ADDR_CONST_A, 32'h00000007);
    rd(ADDR_READBACK);
    chk(rv, 32'h00000007);
    wr(ADDR_STAT, 32'h00000001);
    chk(irq, 1'b0);
    wr(ADDR_CTRL, 32'h00000000);
  endtask

  // Watchdog with filter on, gate high reloads, trigger pin continue/stop
  task automatic t_gate();
    wr(ADDR_BOARD, 32'h00000001);
    wr(ADDR_CTRL, 32'h0000332B);
    wr(ADDR_CONST_A, 32'h000000C8);
    wr(ADDR_TRIG, 32'h00000001);
    cw(100);
    rd(ADDR_READBACK);
    chk(rv, 32'h000000C8);
    set_trig(1'b1);
    cw(300);
    rd(ADDR_READBACK);
    r1 = rv;
    chk_rng(rv, 1, 199);
    set_gate(1'b1);
    cw(100);
    set_gate(1'b0);
    cw(10);
    rd(ADDR_READBACK);
    chk_rng(rv, 1, r1 - 1);
    set_gate(1'b1);
    cw(280);
    rd(ADDR_READBACK);
    chk(rv, 32'h000000C8);
    set_gate(1'b0);
    set_trig(1'b0);
    wr(ADDR_CTRL, 32'h00000000);
    cw(300);
  endtask

  // External clock on the aux pin, started by the trigger pin
  task automatic t_ext();
    wr(ADDR_CTRL, 32'h0000168B);
    wr(ADDR_CONST_A, 32'h00000003);
    pulse(2);
    chk(out, 1'b0);
    set_trig(1'b1);
    cw(10);
    chk(out, 1'b1);
    pulse(2);
    chk(out, 1'b1);
    pulse(1);
    chk(out, 1'b0);
    set_trig(1'b0);
    wr(ADDR_CTRL, 32'h00000000);
  endtask

  task automatic t_evt();
    wr(ADDR_CTRL, 32'h00000784);
    wr(ADDR_TRIG, 32'h00000001);
    pulse(2);
    chk(oe_n, 1'b1);
    rd(ADDR_READBACK);
    chk(rv, 32'h00000000);
    wr(ADDR_CTRL, 32'h00008384);
    wr(ADDR_CONST_A, 32'h00000003);
    wr(ADDR_TRIG, 32'h00000001);
    pulse(2);
    rd(ADDR_READBACK);
    chk(rv, 32'h00000002);
    set_trig(1'b1);
    pulse(1);
    rd(ADDR_READBACK);
    chk(rv, 32'h00000001);
    set_trig(1'b0);
    pulse(1);
    @(posedge i_clock);
    aux <= 1'b1;
    wait_out(1'b0);
    t0 = cyc;
    wait_out(1'b1);
    chk_rng(32'(cyc - t0), 32'(PULSE_CYC) - 2, 32'(PULSE_CYC) + 2);
    chk(irq, 1'b1);
    @(posedge i_clock);
    aux <= 1'b0;
    rd(ADDR_READBACK);
    chk(rv, 32'h00000000);
    set_trig(1'b1);
    pulse(1);
    rd(ADDR_READBACK);
    chk(rv, 32'h00000000);
    wr(ADDR_CTRL, 32'h00000384);
    chk(irq, 1'b0);
    set_trig(1'b0);
    wr(ADDR_CTRL, 32'h00000000);
  endtask

  // PWM: A=4 ticks inactive, B=6 ticks active, tick of 3 cycles
  task automatic t_pwm();
    wr(ADDR_CTRL, 32'h0000900A);
    wr(ADDR_CONST_A, 32'h00000004);
    wr(ADDR_CONST_B, 32'h00000006);
    wr(ADDR_TRIG, 32'h00000001);
    wait_out(1'b1);
    t0 = cyc;
    chk(irq, 1'b1);
    wr(ADDR_STAT, 32'h00000001);
    chk(irq, 1'b0);
    wait_out(1'b0);
    chk_rng(32'(cyc - t0), 15, 24);
    cw(1);
    chk(irq, 1'b1);
    t0 = cyc;
    wait_out(1'b1);
    chk_rng(32'(cyc - t0), 9, 18);
    // Gate field 01: a high gate pin halts the countdown, low lets it resume
    wr(ADDR_CTRL, 32'h0000901A);
    set_gate(1'b1);
    cw(5);
    rd(ADDR_READBACK);
    r1 = rv;
    cw(30);
    rd(ADDR_READBACK);
    chk(rv, r1);
    set_gate(1'b0);
    cw(6);
    rd(ADDR_READBACK);
    chk((rv != r1), 1'b1);
    wr(ADDR_CTRL, 32'h00000000);
  endtask

  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Run is about 5000 cycles; the watchdog allows about twelve times that
  initial begin
    #600000;
    err_count++;
    give_verdict();
  end

  initial begin
    i_rst = 1'b1;
    gate = 1'b0;
    aux = 1'b0;
    trig = 1'b0;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    cw(1);
    t_reset();
    t_wd(1'b1, 3'h4, 3);
    t_wd(1'b0, 3'h4, 12);
    t_wd(1'b1, 3'h3, 6);
    t_wd(1'b0, 3'h1, 100);
    t_gate();
    t_ext();
    t_evt();
    t_pwm();
    give_verdict();
  end
endmodule
